// ===== pkg/spi_pins_pkg.sv
// Purpose: Shared constants for the serial flash pin interface
// Assumes: Pin levels are sampled by the 25 MHz system clock
// Notes: Bit order on the wire is most significant bit first
package spi_pins_pkg;
    // Byte framing on the serial lines
    localparam int BYTE_BITS = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
    localparam logic [BIT_CNT_W-1:0] STEP_SINGLE = 3'h1;
    localparam logic [BIT_CNT_W-1:0] STEP_DUAL = 3'h2;
    localparam logic [BYTE_BITS-1:0] BYTE_ZERO = 8'h00;

    // Idle levels held by the synchronisers during reset
    localparam logic SCK_IDLE = 1'h0;
    localparam logic CS_N_IDLE = 1'h1;
    localparam logic SI_IDLE = 1'h0;
    localparam logic WP_N_IDLE = 1'h1;

    // Link state as seen from the device
    typedef enum logic [1:0] {
        LINK_STANDBY,
        LINK_SELECTED,
        LINK_FINISHING
    } link_state_t;
endpackage

// ===== hw/sync_2ff.sv
// Purpose: Two flip-flop synchroniser for one asynchronous pin
// Assumes: d comes from outside the clk domain
// Notes: Only the second stage leaves this module
`timescale 1ns/1ns
module sync_2ff #(
    parameter logic RESET_VAL = 1'h0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic d,
    output logic q
);
    logic meta;

    // First stage feeds nothing but the second
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ===== hw/spi_flash_pins.sv
// Purpose: Pin-level serial link of a small serial flash, device side
// Assumes: sck runs well below clk/4 so every sck edge is seen after sync
// Notes: The command decoder and array sit behind the user-side ports
`timescale 1ns/1ns
// How it works
// RULE_01: Works with clock idling low or high; either mode needs no setting.
// RULE_02: A frame opens on chip select falling and closes on it rising.
// RULE_03: With chip select high the link drops to standby.
// RULE_04: A running program or erase holds the device active until finished.
// RULE_05: Output lines are released while deselected.
// RULE_06: Input line is ignored while deselected.
// RULE_07: Command, address and write bits are sampled on rising clock edges.
// RULE_08: Read bits are shifted out on falling clock edges.
// RULE_09: Dual reads drive two bits per falling edge, input line included.
// RULE_10: Write-protect low locks the sector protection state.
// RULE_11: Write-protect defaults high when undriven.
// RULE_12: A frame cut short is discarded and changes nothing.
module spi_flash_pins (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic dual_data_line_low_in,
    output logic dual_data_line_low_out,
    output logic dual_data_line_low_oe,
    output logic dual_data_line_high_out,
    output logic dual_data_line_high_oe,
    input wire logic wp_n,
    input wire logic busy,
    input wire logic cmd_complete,
    input wire logic tx_en,
    input wire logic tx_dual,
    input wire logic [7:0] tx_data,
    output logic tx_take,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_first,
    output logic frame_start,
    output logic frame_commit,
    output logic frame_discard,
    output logic selected,
    output logic standby,
    output logic mode3,
    output logic hw_locked
);
    logic sck_s;
    logic sck_d;
    logic cs_n_s;
    logic cs_n_d;
    logic si_s;
    logic wp_n_s;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic seen_rise;
    logic got_byte;
    logic [spi_pins_pkg::BIT_CNT_W-1:0] rx_cnt;
    logic [spi_pins_pkg::BYTE_BITS-1:0] rx_shift;
    logic [spi_pins_pkg::BIT_CNT_W-1:0] tx_cnt;
    logic [spi_pins_pkg::BYTE_BITS-1:0] tx_shift;
    logic tx_dual_run;
    logic [spi_pins_pkg::BIT_CNT_W-1:0] tx_step;
    spi_pins_pkg::link_state_t state;
    spi_pins_pkg::link_state_t next_state;

    // Every pin crosses two flops before logic reads it
    sync_2ff #(.RESET_VAL(spi_pins_pkg::SCK_IDLE)) u_sync_sck (
        .clk(clk), .rstn(rstn), .d(sck), .q(sck_s)
    );
    sync_2ff #(.RESET_VAL(spi_pins_pkg::CS_N_IDLE)) u_sync_cs (
        .clk(clk), .rstn(rstn), .d(cs_n), .q(cs_n_s)
    );
    sync_2ff #(.RESET_VAL(spi_pins_pkg::SI_IDLE)) u_sync_si (
        .clk(clk), .rstn(rstn), .d(dual_data_line_low_in), .q(si_s)
    );
    // Reset value high mirrors the internal pull-up  // see RULE_11
    sync_2ff #(.RESET_VAL(spi_pins_pkg::WP_N_IDLE)) u_sync_wp (
        .clk(clk), .rstn(rstn), .d(wp_n), .q(wp_n_s)
    );

    // Edge history of the synchronised clock and select
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_d <= spi_pins_pkg::SCK_IDLE;
            cs_n_d <= spi_pins_pkg::CS_N_IDLE;
        end
        else
        begin
            sck_d <= sck_s;
            cs_n_d <= cs_n_s;
        end
    end

    // Clock edges count only inside a frame  // see RULE_06
    assign sck_rise = sck_s && !sck_d && !cs_n_s;
    assign sck_fall = !sck_s && sck_d && !cs_n_s;
    assign cs_fall = !cs_n_s && cs_n_d;  // see RULE_02
    assign cs_rise = cs_n_s && !cs_n_d;  // see RULE_02

    // Link state; deselect waits for a self-timed operation to finish
    always_comb
    begin
        next_state = state;
        case (state)
            spi_pins_pkg::LINK_STANDBY:
                if (cs_fall)
                    next_state = spi_pins_pkg::LINK_SELECTED;
            spi_pins_pkg::LINK_SELECTED:
                if (cs_rise)
                    next_state = busy ? spi_pins_pkg::LINK_FINISHING  // see RULE_04
                                      : spi_pins_pkg::LINK_STANDBY;   // see RULE_03
            spi_pins_pkg::LINK_FINISHING:
                if (cs_fall)
                    next_state = spi_pins_pkg::LINK_SELECTED;
                else if (!busy)
                    next_state = spi_pins_pkg::LINK_STANDBY;  // see RULE_04
            default:
                next_state = spi_pins_pkg::LINK_STANDBY;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state <= spi_pins_pkg::LINK_STANDBY;
        else
            state <= next_state;
    end

    assign selected = (state == spi_pins_pkg::LINK_SELECTED);
    assign standby = (state == spi_pins_pkg::LINK_STANDBY);  // see RULE_03

    // Clock level at select tells the mode; nothing else depends on it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            mode3 <= 1'h0;
        else if (cs_fall)
            mode3 <= sck_s;  // see RULE_01
    end

    // In mode 3 the first falling edge precedes any data; it is skipped
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            seen_rise <= 1'h0;
        else if (cs_fall)
            seen_rise <= 1'h0;  // see RULE_01
        else if (sck_rise)
            seen_rise <= 1'h1;
    end

    // Input shifter samples on rising edges while not sending
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_cnt <= spi_pins_pkg::BIT_CNT_ZERO;
            rx_shift <= spi_pins_pkg::BYTE_ZERO;
            rx_data <= spi_pins_pkg::BYTE_ZERO;
            rx_valid <= 1'h0;
            rx_first <= 1'h0;
            got_byte <= 1'h0;
        end
        else
        begin
            rx_valid <= 1'h0;
            if (cs_fall)
            begin
                // A fresh frame drops any partial bits left behind  // see RULE_12
                rx_cnt <= spi_pins_pkg::BIT_CNT_ZERO;
                got_byte <= 1'h0;
            end
            else if (sck_rise && !tx_en)
            begin
                rx_shift <= {rx_shift[spi_pins_pkg::BYTE_BITS-2:0], si_s};  // see RULE_07
                rx_cnt <= rx_cnt + spi_pins_pkg::STEP_SINGLE;
                if (rx_cnt == spi_pins_pkg::BIT_CNT_LAST)
                begin
                    rx_data <= {rx_shift[spi_pins_pkg::BYTE_BITS-2:0], si_s};
                    rx_valid <= 1'h1;
                    rx_first <= !got_byte;
                    got_byte <= 1'h1;
                end
            end
        end
    end

    // Frame boundary pulses; an incomplete frame is never committed
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frame_start <= 1'h0;
            frame_commit <= 1'h0;
            frame_discard <= 1'h0;
        end
        else
        begin
            frame_start <= cs_fall;  // see RULE_02
            frame_commit <= cs_rise && selected && cmd_complete
                && got_byte && (rx_cnt == spi_pins_pkg::BIT_CNT_ZERO);
            frame_discard <= cs_rise && selected && !(cmd_complete
                && got_byte && (rx_cnt == spi_pins_pkg::BIT_CNT_ZERO));  // see RULE_12
        end
    end

    // Dual mode moves two bits per edge; the counter still wraps at a byte
    assign tx_step = tx_dual_run ? spi_pins_pkg::STEP_DUAL : spi_pins_pkg::STEP_SINGLE;

    // Output shifter changes only on falling edges
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_cnt <= spi_pins_pkg::BIT_CNT_ZERO;
            tx_shift <= spi_pins_pkg::BYTE_ZERO;
            tx_dual_run <= 1'h0;
            tx_take <= 1'h0;
            dual_data_line_high_out <= 1'h0;
            dual_data_line_low_out <= 1'h0;
        end
        else
        begin
            tx_take <= 1'h0;
            if (cs_fall || !tx_en)
            begin
                tx_cnt <= spi_pins_pkg::BIT_CNT_ZERO;
                tx_dual_run <= 1'h0;
            end
            else if (sck_fall && seen_rise)
            begin
                if (tx_cnt == spi_pins_pkg::BIT_CNT_ZERO)
                begin
                    // Byte boundary: take a new byte and fix its width
                    tx_take <= 1'h1;
                    tx_dual_run <= tx_dual;
                    dual_data_line_high_out <= tx_data[spi_pins_pkg::BYTE_BITS-1];  // see RULE_08
                    dual_data_line_low_out <= tx_data[spi_pins_pkg::BYTE_BITS-2];  // see RULE_09
                    tx_shift <= tx_dual
                        ? {tx_data[spi_pins_pkg::BYTE_BITS-3:0], 2'h0}
                        : {tx_data[spi_pins_pkg::BYTE_BITS-2:0], 1'h0};
                    tx_cnt <= tx_dual ? spi_pins_pkg::STEP_DUAL
                                      : spi_pins_pkg::STEP_SINGLE;
                end
                else
                begin
                    dual_data_line_high_out <= tx_shift[spi_pins_pkg::BYTE_BITS-1];  // see RULE_08
                    dual_data_line_low_out <= tx_shift[spi_pins_pkg::BYTE_BITS-2];  // see RULE_09
                    tx_shift <= tx_dual_run
                        ? {tx_shift[spi_pins_pkg::BYTE_BITS-3:0], 2'h0}
                        : {tx_shift[spi_pins_pkg::BYTE_BITS-2:0], 1'h0};
                    tx_cnt <= tx_cnt + tx_step;
                end
            end
        end
    end

    // Drivers are enabled only inside a frame and only once data flows
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dual_data_line_high_oe <= 1'h0;
            dual_data_line_low_oe <= 1'h0;
        end
        else if (!selected || cs_rise || !tx_en)
        begin
            dual_data_line_high_oe <= 1'h0;  // see RULE_05
            dual_data_line_low_oe <= 1'h0;   // see RULE_05
        end
        else if (sck_fall && seen_rise && tx_cnt == spi_pins_pkg::BIT_CNT_ZERO)
        begin
            dual_data_line_high_oe <= 1'h1;  // see RULE_08
            dual_data_line_low_oe <= tx_dual;  // see RULE_09
        end
    end

    // Protection changes are refused while write-protect is low
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hw_locked <= 1'h0;
        else
            hw_locked <= !wp_n_s;  // see RULE_10
    end
endmodule

// ===== sim/spi_flash_pins_monitor.sv
// Purpose: Concurrent checks on the flash pin interface
// Assumes: Pins reach clk through two flops plus an edge detect
// Notes: Windows give one or two clk of slack on pin latency
`timescale 1ns/1ns
module spi_flash_pins_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic wp_n,
    input wire logic busy,
    input wire logic dual_data_line_low_oe,
    input wire logic dual_data_line_high_oe,
    input wire logic tx_take,
    input wire logic rx_valid,
    input wire logic frame_start,
    input wire logic frame_commit,
    input wire logic frame_discard,
    input wire logic standby,
    input wire logic hw_locked
);
    // One domain, so clock and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    frame_opens_a: assert property ($fell(cs_n) |-> ##[3:5] frame_start)
        else $error("frame start missing after select");
    goes_standby_a: assert property ((cs_n && !busy)[*6] |-> standby)
        else $error("no standby while idle");
    busy_active_a: assert property (busy[*2] |-> !standby)
        else $error("standby while busy");
    lines_released_a: assert property (cs_n[*5] |-> !dual_data_line_high_oe
        && !dual_data_line_low_oe)
        else $error("line driven while deselected");
    input_ignored_a: assert property (cs_n[*6] |-> !rx_valid && !frame_start)
        else $error("activity accepted while deselected");
    rx_on_rise_a: assert property (rx_valid |-> $past(sck, 2))
        else $error("byte taken away from a rising edge");
    take_on_fall_a: assert property (tx_take |-> !$past(sck, 2))
        else $error("byte shifted away from a falling edge");
    dual_pair_a: assert property (dual_data_line_low_oe |-> dual_data_line_high_oe)
        else $error("low line driven alone");
    lock_on_low_a: assert property ((!wp_n)[*5] |-> hw_locked)
        else $error("no lock with protect low");
    unlock_on_high_a: assert property (wp_n[*5] |-> !hw_locked)
        else $error("lock with protect high");
    end_once_a: assert property ((frame_commit || frame_discard) |-> $past(cs_n, 2)
        && !(frame_commit && frame_discard))
        else $error("frame end without deselect or both kept and dropped");
    commit_c: cover property (frame_commit);
    discard_c: cover property (frame_discard);
    dual_c: cover property ($rose(dual_data_line_low_oe));
endmodule
bind spi_flash_pins spi_flash_pins_monitor spi_flash_pins_monitor_i (.*);

// ===== sim/spi_host_model.sv
// Purpose: Behavioural SPI host for the flash pins
// Assumes: Link period 320 ns, every pin edge lands 1 ns after a clk edge
// Notes: Output bits are taken late in the high phase, long after they settle
`timescale 1ns/1ns
module spi_host_model (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic si_en,
    input wire logic so,
    input wire logic io_low
);
    // Idle: deselected, link clock still
    initial
    begin
        sck = 1'h0;
        cs_n = 1'h1;
        si = 1'h0;
        si_en = 1'h1;
    end
    // Clock idles high in mode 3, low in mode 0
    task automatic open_frame(input logic m3);
        sck = m3;
        #40 cs_n = 1'h0;
        #160;
    endtask
    // Dual steps release si and take two bits per step
    task automatic xfer(input logic [7:0] tx, input int n, input logic dual,
        output logic [7:0] rx);
        rx = 8'h00;
        si_en = !dual;
        for (int k = 0; k < n; k++)
        begin
            sck = 1'h0;
            si = tx[7 - k];
            #160 sck = 1'h1;
            #150 rx = dual ? {rx[5:0], so, io_low} : {rx[6:0], so};
            #10;
        end
    endtask
    task automatic close_frame(input logic m3);
        if (!m3)
            sck = 1'h0;
        #160 cs_n = 1'h1;
        si_en = 1'h1;
    endtask
endmodule

// ===== sim/test_spi_flash_pins.sv
// Purpose: Self-checking bench for the flash pin interface
// Assumes: Bench plays the core side; the host model drives the pins
// Notes: Released lines read back inverted so a stale value never passes
`timescale 1ns/1ns
module test_spi_flash_pins;
    logic clk = 1'h0, rstn = 1'h0, busy = 1'h0, cmd_complete = 1'h0, tx_en = 1'h0;
    logic tx_dual = 1'h0, wp_en = 1'h0, wp_val = 1'h1;
    logic [7:0] tx_data = 8'h00, rx_data;
    logic sck, cs_n, si, si_en, so_pin, wp_n, dual_data_line_low_in, dual_data_line_low_out;
    logic dual_data_line_low_oe, dual_data_line_high_out, dual_data_line_high_oe, tx_take;
    logic rx_valid, rx_first, frame_start, frame_commit, frame_discard, selected, standby;
    logic mode3, hw_locked;
    logic [8:0] got_rx = 9'h000;
    int fail_count = 0, compares = 0, cycles = 0, commits = 0, discards = 0, rx_count = 0;
    // Pull-up on protect; undriven lines show the inverse of their last level
    assign wp_n = wp_en ? wp_val : 1'h1;
    assign dual_data_line_low_in = dual_data_line_low_oe ? dual_data_line_low_out
        : (si_en ? si : !si);
    assign so_pin = dual_data_line_high_oe ? dual_data_line_high_out : !dual_data_line_high_out;
    spi_flash_pins spi_flash_pins_i (.*);
    spi_host_model spi_host_model_i (.sck(sck), .cs_n(cs_n), .si(si), .si_en(si_en),
        .so(so_pin), .io_low(dual_data_line_low_in));
    always #20 clk = !clk;
    // Event log and hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (rx_valid)
            got_rx = {rx_first, rx_data};
        rx_count += int'(rx_valid);
        commits += int'(frame_commit);
        discards += int'(frame_discard);
        if (cycles == 20000)
            give_verdict(1);
    end
    task automatic give_verdict(input int late);
        fail_count += late;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Command byte, then one read byte in single or dual width
    task automatic read_test(input logic m3, input logic dual, input logic [7:0] data);
        logic [7:0] rx;
        int c0;
        c0 = commits;
        spi_host_model_i.open_frame(m3);
        spi_host_model_i.xfer(8'hA5, 8, 1'h0, rx);
        tick(3);
        check("mode", {8'h00, m3}, {8'h00, mode3});
        check("command", 9'h1A5, got_rx);
        tx_en = 1'h1;
        cmd_complete = 1'h1;
        tx_dual = dual;
        tx_data = data;
        spi_host_model_i.xfer(8'h00, dual ? 4 : 8, dual, rx);
        check("read", {1'h0, data}, {1'h0, rx});
        check("low enable", {8'h00, dual}, {8'h00, dual_data_line_low_oe});
        spi_host_model_i.close_frame(m3);
        tick(6);
        check("commit", 9'h001, 9'(commits - c0));
        check("idle", 9'h001, {6'h00, dual_data_line_high_oe, dual_data_line_low_oe, standby});
        tx_en = 1'h0;
        cmd_complete = 1'h0;
        $display("read test done");
    endtask
    // Clocking while deselected, then a frame cut mid-byte
    task automatic discard_test();
        logic [7:0] rx;
        int c0, d0, r0;
        c0 = commits;
        d0 = discards;
        r0 = rx_count;
        spi_host_model_i.xfer(8'hFF, 8, 1'h0, rx);
        tick(6);
        check("ignored", 9'h000, 9'(rx_count - r0));
        spi_host_model_i.open_frame(1'h0);
        spi_host_model_i.xfer(8'h3C, 5, 1'h0, rx);
        spi_host_model_i.close_frame(1'h0);
        tick(6);
        check("cut frame", 9'h001, {1'h0, 4'(commits - c0), 4'(discards - d0)});
        $display("discard test done");
    endtask
    // Self-timed work keeps the link out of standby
    task automatic busy_test();
        logic [7:0] rx;
        spi_host_model_i.open_frame(1'h0);
        spi_host_model_i.xfer(8'h06, 8, 1'h0, rx);
        tick(3);
        cmd_complete = 1'h1;
        busy = 1'h1;
        spi_host_model_i.close_frame(1'h0);
        tick(6);
        check("busy state", 9'h000, {7'h00, selected, standby});
        busy = 1'h0;
        cmd_complete = 1'h0;
        tick(3);
        check("standby", 9'h001, {8'h00, standby});
        $display("busy test done");
    endtask
    task automatic protect_test();
        tick(5);
        check("floating protect", 9'h000, {8'h00, hw_locked});
        wp_en = 1'h1;
        wp_val = 1'h0;
        tick(5);
        check("protect low", 9'h001, {8'h00, hw_locked});
        wp_val = 1'h1;
        tick(5);
        check("protect high", 9'h000, {8'h00, hw_locked});
        $display("protect test done");
    endtask
    initial
    begin
        tick(2);
        rstn = 1'h1;
        tick(4);
        read_test(1'h0, 1'h0, 8'hC6);
        read_test(1'h1, 1'h1, 8'h5A);
        discard_test();
        busy_test();
        protect_test();
        give_verdict(0);
    end
endmodule
